// [core/dcrc_params.svh]
`ifndef DCRC_PARAMS_SVH
`define DCRC_PARAMS_SVH
// Avalon register word byte addresses.
`define DCRC_ADDR_CFG_LO 4'h0
`define DCRC_ADDR_CFG_HI 4'h4
`define DCRC_ADDR_STATUS 4'h8
`define DCRC_ADDR_RATIO 4'hC
// Configuration word field positions.
`define DCRC_POS_RATIO_LSB 10
`define DCRC_POS_RANGE_LSB 0
`define DCRC_POS_SYNC 184
`define DCRC_POS_RATE 232
`define DCRC_POS_RSV 234
`define DCRC_CW_WIDTH 256
// Ratio select codes.
`define DCRC_RAT_SYNC_1 5'h01
`define DCRC_RAT_5 5'h05
`define DCRC_RAT_6 5'h06
`define DCRC_RAT_8 5'h08
`define DCRC_RAT_9 5'h09
`define DCRC_RAT_10 5'h0A
`define DCRC_RAT_12 5'h0C
`define DCRC_RAT_13 5'h0D
`define DCRC_RAT_16 5'h10
`define DCRC_RAT_18 5'h12
`define DCRC_RAT_19 5'h13
`define DCRC_RAT_20 5'h14
`define DCRC_RAT_24 5'h18
// Range settings.
`define DCRC_RNG_01 2'h1
`define DCRC_RNG_10 2'h2
`define DCRC_RNG_11 2'h3
`endif

// [core/dcrc_pkg.sv]
package dcrc_pkg;
   // Clock source of the DDR PLL.
   typedef enum logic [1:0] {
      DCRC_SRC_ASYNC = 2'h1,
      DCRC_SRC_SYNC = 2'h2
   } dcrc_src_e;
   // Decoder sequencing states.
   typedef enum logic [2:0] {
      DCRC_ST_RESET = 3'h1,
      DCRC_ST_SAMPLE = 3'h2,
      DCRC_ST_RUN = 3'h4
   } dcrc_state_e;
endpackage

// [core/dcrc_top.sv]
// Function
// - One shared configuration drives both controllers
// - Async uses reference clock, sync platform
// - Async multiplier from bits 10 to 14
// - Decode the twelve async ratio codes
// - Sync field means ratio to platform
// - Sync supports only code 0_0001
// - Memory bus clock is half rate
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`include "dcrc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcrc_top (
   // Clock and synchronous reset.
   input wire logic mclk_i,
   input wire logic reset_i,
   // Configuration word pins, static but from outside the clock domain.
   input wire logic [255:0] reset_configuration_word_i,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Clock selection shared by both memory controllers.
   output logic ddr_src_sync_o,
   output logic [4:0] ddr_multiplier_o,
   output logic [1:0] ddr_pll_range_o,
   output logic mem_bus_half_rate_o,
   output logic config_valid_o,
   output logic config_error_o
);
   // Two-stage synchroniser for the configuration word.
   logic [255:0] cw_meta_reg;
   logic [255:0] cw_sync_reg;
   // Latched fields.
   logic sync_reg, sync_next;
   logic rate_reg, rate_next;
   logic rsv_reg, rsv_next;
   logic [4:0] ratio_reg, ratio_next;
   logic [1:0] range_reg, range_next;
   logic [4:0] mult_reg, mult_next;
   logic err_reg, err_next;
   // Cause bits, high to low: reserved bit, mode mismatch, reserved code, bad pairing.
   logic [3:0] cause_reg, cause_next;
   logic valid_reg, valid_next;
   dcrc_pkg::dcrc_state_e state_reg, state_next;
   // Bus answer registers.
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next;
   logic [1:0] ref_hint_reg, ref_hint_next;
   // Decoder scratch values.
   logic [4:0] dec_mult;
   logic dec_pair_ok;
   logic [4:0] f_ratio;
   logic [1:0] f_range;
   logic f_sync, f_rate, f_rsv;

   // Synchroniser; the first stage is read only by the second.
   always_ff @(posedge mclk_i) begin
      cw_meta_reg <= reset_configuration_word_i;
      cw_sync_reg <= cw_meta_reg;
   end

   // Field extraction from the synchronised word.
   always_comb begin
      f_ratio = cw_sync_reg[`DCRC_POS_RATIO_LSB +: 5];
      f_range = cw_sync_reg[`DCRC_POS_RANGE_LSB +: 2];
      f_sync = cw_sync_reg[`DCRC_POS_SYNC];
      f_rate = cw_sync_reg[`DCRC_POS_RATE];
      f_rsv = cw_sync_reg[`DCRC_POS_RSV];
   end

   // Ratio decode and range pairing check. The reference frequency is
   // unknown to logic, so ratio 8 and 9 accept either legal range; the
   // software hint register is cleared by reset and still reads zero when the word is latched, so it never narrows this.
   always_comb begin
      dec_mult = 5'h00;
      dec_pair_ok = 1'b0;
      if (f_sync) begin
         // Only one-to-one against the platform clock exists.
         if (f_ratio == `DCRC_RAT_SYNC_1) begin
            dec_mult = 5'h01;
            dec_pair_ok = (f_range == `DCRC_RNG_01) || (ref_hint_reg == 2'h1);
         end
      end else begin
         case (f_ratio)
            // The lowest ratio pairs with any range setting.
            `DCRC_RAT_5: begin
               dec_mult = 5'h05;
               dec_pair_ok = 1'b1;
            end
            // Ratio 6 needs range 11; keeping the reference slow enough is the board's duty.
            `DCRC_RAT_6: begin
               dec_mult = 5'h06;
               dec_pair_ok = (f_range == `DCRC_RNG_11);
            end
            `DCRC_RAT_8: begin
               dec_mult = 5'h08;
               // Hint 1 means reference below threshold, 2 at or above.
               if (ref_hint_reg == 2'h1) begin
                  dec_pair_ok = (f_range == `DCRC_RNG_10);
               end else if (ref_hint_reg == 2'h2) begin
                  dec_pair_ok = (f_range == `DCRC_RNG_01);
               end else begin
                  dec_pair_ok = (f_range == `DCRC_RNG_10) || (f_range == `DCRC_RNG_01);
               end
            end
            `DCRC_RAT_9: begin
               dec_mult = 5'h09;
               if (ref_hint_reg == 2'h1) begin
                  dec_pair_ok = (f_range == `DCRC_RNG_10);
               end else if (ref_hint_reg == 2'h2) begin
                  dec_pair_ok = (f_range == `DCRC_RNG_01);
               end else begin
                  dec_pair_ok = (f_range == `DCRC_RNG_10) || (f_range == `DCRC_RNG_01);
               end
            end
            `DCRC_RAT_10: begin
               dec_mult = 5'h0A;
               dec_pair_ok = (f_range == `DCRC_RNG_01);
            end
            // The upper middle ratios all need range 11.
            `DCRC_RAT_12: begin
               dec_mult = 5'h0C;
               dec_pair_ok = (f_range == `DCRC_RNG_11);
            end
            `DCRC_RAT_13: begin
               dec_mult = 5'h0D;
               dec_pair_ok = (f_range == `DCRC_RNG_11);
            end
            `DCRC_RAT_16: begin
               dec_mult = 5'h10;
               dec_pair_ok = (f_range == `DCRC_RNG_11);
            end
            // The high ratios pair with any range setting.
            `DCRC_RAT_18: begin
               dec_mult = 5'h12;
               dec_pair_ok = 1'b1;
            end
            `DCRC_RAT_19: begin
               dec_mult = 5'h13;
               dec_pair_ok = 1'b1;
            end
            `DCRC_RAT_20: begin
               dec_mult = 5'h14;
               dec_pair_ok = 1'b1;
            end
            `DCRC_RAT_24: begin
               dec_mult = 5'h18;
               dec_pair_ok = 1'b1;
            end
            // Reserved codes give no multiplier and fail the pairing as well.
            default: begin
               dec_mult = 5'h00;
               dec_pair_ok = 1'b0;
            end
         endcase
      end
   end

   // Sequencer: wait for the synchroniser to fill, sample once, then hold.
   // Configuration is static, so it is latched only once after reset.
   always_comb begin
      state_next = state_reg;
      sync_next = sync_reg;
      rate_next = rate_reg;
      rsv_next = rsv_reg;
      ratio_next = ratio_reg;
      range_next = range_reg;
      mult_next = mult_reg;
      err_next = err_reg;
      cause_next = cause_reg;
      valid_next = valid_reg;
      case (state_reg)
         // One spare cycle after reset lets the synchronised word settle.
         dcrc_pkg::DCRC_ST_RESET: begin
            state_next = dcrc_pkg::DCRC_ST_SAMPLE;
         end
         // Every field and the verdict are latched in this one cycle.
         dcrc_pkg::DCRC_ST_SAMPLE: begin
            sync_next = f_sync;
            rate_next = f_rate;
            rsv_next = f_rsv;
            ratio_next = f_ratio;
            range_next = f_range;
            mult_next = dec_mult;
            cause_next = {f_rsv, (f_sync != f_rate), (dec_mult == 5'h00), ~dec_pair_ok};
            err_next = f_rsv || (f_sync != f_rate) || (dec_mult == 5'h00) || !dec_pair_ok;
            valid_next = 1'b1;
            state_next = dcrc_pkg::DCRC_ST_RUN;
         end
         // The latched configuration holds until the next reset.
         dcrc_pkg::DCRC_ST_RUN: begin
            state_next = dcrc_pkg::DCRC_ST_RUN;
         end
         // An illegal state code restarts the sequence.
         default: begin
            state_next = dcrc_pkg::DCRC_ST_RESET;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_reg <= dcrc_pkg::DCRC_ST_RESET;
         sync_reg <= 1'b0;
         rate_reg <= 1'b0;
         rsv_reg <= 1'b0;
         ratio_reg <= 5'h00;
         range_reg <= 2'h0;
         mult_reg <= 5'h00;
         err_reg <= 1'b0;
         cause_reg <= 4'h0;
         valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sync_reg <= sync_next;
         rate_reg <= rate_next;
         rsv_reg <= rsv_next;
         ratio_reg <= ratio_next;
         range_reg <= range_next;
         mult_reg <= mult_next;
         err_reg <= err_next;
         cause_reg <= cause_next;
         valid_reg <= valid_next;
      end
   end

   // Avalon slave: each access answers one cycle after it is presented.
   // Waitrequest is high by default and drops for one cycle per access.
   // The registered waitrequest costs a cycle per access, which is harmless
   // because software reads these words only a few times after boot.
   always_comb begin
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      ref_hint_next = ref_hint_reg;
      if ((avs_read_i || avs_write_i) && wait_reg) begin
         // New request: answer in the next cycle with the read word ready.
         wait_next = 1'b0;
         if (avs_read_i) begin
            if (avs_address_i == `DCRC_ADDR_CFG_LO) begin
               rdata_next = {17'h0, ratio_reg, 8'h00, range_reg};
            end else if (avs_address_i == `DCRC_ADDR_CFG_HI) begin
               rdata_next = {29'h0, rsv_reg, rate_reg, sync_reg};
            end else if (avs_address_i == `DCRC_ADDR_STATUS) begin
               rdata_next = {26'h0, cause_reg, err_reg, valid_reg};
            end else if (avs_address_i == `DCRC_ADDR_RATIO) begin
               rdata_next = {22'h0, ref_hint_reg, 3'h0, mult_reg};
            end else begin
               // Unmapped words read as zero.
               rdata_next = 32'h00000000;
            end
         end
      end else if (avs_write_i && !wait_reg) begin
         // The master still holds the write while it sees waitrequest low,
         // so the write lands at that edge and not at the one that took it.
         if ((avs_address_i == `DCRC_ADDR_RATIO) && avs_byteenable_i[1]) begin
            // Reference-range hint: 1 below the threshold, 2 at or above.
            ref_hint_next = avs_writedata_i[9:8];
         end
      end
      // A request still held in the answer cycle falls to the default high,
      // so one request is never answered twice.
   end

   // Bus registers.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         ref_hint_reg <= 2'h0;
      end else begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         ref_hint_reg <= ref_hint_next;
      end
   end

   // Outputs straight from flip-flops.
   // Both controllers see one multiplier and one range, so they cannot differ.
   always_comb begin
      avs_readdata_o = rdata_reg;
      avs_waitrequest_o = wait_reg;
      ddr_src_sync_o = sync_reg;
      ddr_multiplier_o = mult_reg;
      ddr_pll_range_o = range_reg;
      mem_bus_half_rate_o = valid_reg;
      config_valid_o = valid_reg;
      config_error_o = err_reg;
   end
endmodule
`default_nettype wire

// [sim/dcrc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the decoded clock selection and the bus handshake of the block.
module dcrc_checker (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic reset_i,
   // Inputs of the block.
   input wire logic [255:0] reset_configuration_word_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   // Outputs under watch.
   input wire logic avs_waitrequest_o,
   input wire logic ddr_src_sync_o,
   input wire logic [4:0] ddr_multiplier_o,
   input wire logic [1:0] ddr_pll_range_o,
   input wire logic mem_bus_half_rate_o,
   input wire logic config_valid_o,
   input wire logic config_error_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   // The word only changes under reset, so it is compared directly.
   wire logic [255:0] w = reset_configuration_word_i;
   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ans;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   a_bus_answer: assert property (s_req |=> s_ans) else $error("bus answer wrong");
   a_src_mode: assert property (config_valid_o |-> ddr_src_sync_o == w[184])
      else $error("clock source wrong");
   a_range_copy: assert property (config_valid_o |-> ddr_pll_range_o == w[1:0])
      else $error("range wrong");
   a_sync_mult: assert property (config_valid_o && w[184]
      |-> ddr_multiplier_o == {4'h0, w[14:10] == 5'h01}) else $error("sync multiplier wrong");
   a_async_mult: assert property (config_valid_o && !w[184] && ddr_multiplier_o != 5'h00
      |-> ddr_multiplier_o == w[14:10]) else $error("async multiplier wrong");
   a_half_rate: assert property (config_valid_o |-> mem_bus_half_rate_o)
      else $error("half rate missing");
   a_mode_err: assert property (config_valid_o && ((w[184] ^ w[232]) | w[234])
      |-> config_error_o) else $error("mode error missing");
   a_code_err: assert property (config_valid_o && ddr_multiplier_o == 5'h00
      |-> config_error_o) else $error("code error missing");
   a_valid_soon: assert property ($fell(reset_i) |-> ##[1:3] config_valid_o)
      else $error("valid late");
endmodule
bind dcrc_top dcrc_checker u_chk (.mclk_i, .reset_i, .reset_configuration_word_i, .avs_read_i,
   .avs_write_i, .avs_waitrequest_o, .ddr_src_sync_o, .ddr_multiplier_o, .ddr_pll_range_o,
   .mem_bus_half_rate_o, .config_valid_o, .config_error_o);
`default_nettype wire

// [sim/ddr_clock_ratio_config_test.sv]
`timescale 1ns/1ps
`default_nettype none
module ddr_clock_ratio_config_test;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [255:0] cw = 256'h0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata;
   logic wait_o;
   logic src;
   logic [4:0] mult;
   logic [1:0] rng;
   logic half;
   logic valid;
   logic err;
   logic prev_valid = 1'b0;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 32'h2715;
   int test_no = 0;
   // Notes of expected results: read {mask, value} and config outputs.
   logic [63:0] rq[$];
   logic [9:0] cq[$];
   always #10 mclk_i = ~mclk_i;
   dcrc_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .reset_configuration_word_i(cw),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .ddr_src_sync_o(src), .ddr_multiplier_o(mult), .ddr_pll_range_o(rng),
      .mem_bus_half_rate_o(half), .config_valid_o(valid), .config_error_o(err));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Range that the far side must pair with each code while no hint is given.
   function automatic logic [1:0] good_range(input logic [4:0] c);
      case (c)
         5'h06, 5'h0C, 5'h0D, 5'h10: return 2'h3;
         5'h08, 5'h09: return 2'h2;
         default: return 2'h1;
      endcase
   endfunction
   // Expected {src, multiplier, range, half rate, error} for a word.
   function automatic logic [9:0] expect_cfg(input logic [255:0] w);
      logic [4:0] c;
      logic [4:0] m;
      logic bad;
      c = w[14:10];
      m = 5'h00;
      case (c)
         5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h10, 5'h12, 5'h13, 5'h14, 5'h18: m = c;
         default: m = 5'h00;
      endcase
      if (w[184]) begin
         m = (c == 5'h01) ? 5'h01 : 5'h00;
         bad = w[1:0] != 2'h1;
      end else if (c == 5'h08 || c == 5'h09) begin
         bad = w[1:0] != 2'h1 && w[1:0] != 2'h2;
      end else begin
         bad = good_range(c) != 2'h1 && w[1:0] != good_range(c);
         bad = bad || (c == 5'h0A && w[1:0] != 2'h1);
      end
      return {w[184], m, w[1:0], 1'b1, w[234] | (w[184] ^ w[232]) | (m == 5'h00) | bad};
   endfunction
   // One Avalon transfer; it is held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] b, input logic [63:0] e);
      @(posedge mclk_i);
      if (!w) begin
         rq.push_back(e);
      end
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      do @(posedge mclk_i); while (wait_o);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // New word under reset, held stable well past the synchroniser.
   task automatic cfg(input logic [255:0] w);
      logic [9:0] x;
      x = expect_cfg(w);
      @(posedge mclk_i);
      reset_i <= 1'b1;
      cw <= w;
      cq.push_back(x);
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      bus(1'b0, 4'h0, 32'h0, 4'hF, {32'h00007C03, 17'h0, w[14:10], 8'h0, w[1:0]});
      bus(1'b0, 4'h4, 32'h0, 4'hF, {32'h7, 29'h0, w[234], w[232], w[184]});
      bus(1'b0, 4'h8, 32'h0, 4'hF, {32'h33, 26'h0, w[234], w[184] ^ w[232], 2'h0, x[0], 1'b1});
      test_no++;
      $display("test %0d done", test_no);
   endtask
   // Sampled before this edge's updates land, so the values are the settled ones.
   always @(posedge mclk_i) begin
      if (!reset_i && valid && !prev_valid && cq.size() > 0) begin
         check("config", {22'h0, src, mult, rng, half, err}, {22'h0, cq.pop_front()});
      end
      if (!wait_o && rd && rq.size() > 0) begin
         check("readdata", rdata & rq[0][63:32], rq[0][31:0]);
         void'(rq.pop_front());
      end
      prev_valid <= valid;
   end
   // A hang is cut short long after the expected run length.
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      logic [255:0] w;
      repeat (20) @(posedge mclk_i);
      // Every code in asynchronous mode with its accepted range.
      for (int i = 0; i < 32; i++) begin
         for (int k = 0; k < 8; k++) begin
            w[32 * k +: 32] = $random(seed);
         end
         w[14:10] = i[4:0];
         w[1:0] = good_range(i[4:0]);
         w[184] = 1'b0;
         w[232] = 1'b0;
         w[234] = 1'b0;
         cfg(w);
      end
      // Synchronous one-to-one, then random words with occasional faults.
      w[14:10] = 5'h01;
      w[1:0] = 2'h1;
      w[184] = 1'b1;
      w[232] = 1'b1;
      cfg(w);
      for (int i = 0; i < 24; i++) begin
         // Independent words, then the rate bit copies the sync bit and the reserved bit clears in three of four draws.
         for (int k = 0; k < 8; k++) begin
            w[32 * k +: 32] = $random(seed);
         end
         if ($random(seed) & 3) w[232] = w[184];
         if ($random(seed) & 3) w[234] = 1'b0;
         cfg(w);
      end
      // Hint lane writes, a refused lane and an unmapped read.
      bus(1'b1, 4'hC, 32'h00000200, 4'h2, 64'h0);
      bus(1'b0, 4'hC, 32'h0, 4'hF, {32'h00000300, 32'h00000200});
      bus(1'b1, 4'hC, 32'h00000100, 4'h1, 64'h0);
      bus(1'b0, 4'hC, 32'h0, 4'hF, {32'h00000300, 32'h00000200});
      bus(1'b0, 4'h2, 32'h0, 4'hF, {32'hFFFFFFFF, 32'h0});
      repeat (2) @(posedge mclk_i);
      test_no++;
      $display("test %0d done", test_no);
      tally_and_finish();
   end
endmodule
`default_nettype wire
